// [cdio_top.sv]
// Purpose: discrete-pin control of a 24-bit up/down counter, APB registers
// Assumes: pins asynchronous to pclk, APB3 master without pstrb
// Notes: one wait state on every APB access
//
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/1ns
`default_nettype none
module cdio_top (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // count and control pins
  input wire logic count_a,
  input wire logic count_b,
  input wire logic gate_or_reset_pin,
  input wire logic load_target_pin,
  // output pins
  output logic carry_pin,
  output logic borrow_pin,
  // interrupt
  output logic irq
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [3:0] pin_s;
  cdio_sync #(
    .WIDTH(4),
    .RST_VAL(cdio_pkg::PIN_IDLE)
  ) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .din({load_target_pin, gate_or_reset_pin, count_b, count_a}),
    .dout(pin_s)
  );
  wire a_s = pin_s[0];
  wire b_s = pin_s[1];
  wire gate_s = pin_s[2];
  wire load_s = pin_s[3];

  logic a_d;
  logic b_d;
  logic load_d;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_d <= 1'b1;
      b_d <= 1'b1;
      load_d <= 1'b1;
    end else begin
      a_d <= a_s;
      b_d <= b_s;
      load_d <= load_s;
    end
  end
  wire a_rise = a_s & ~a_d;
  wire b_rise = b_s & ~b_d;
  wire load_fall = ~load_s & load_d;

  // ****************************************
  // apb decode
  // ****************************************
  logic [5:0] input_setup_register;
  logic [5:0] output_setup_register;
  logic [23:0] preset_register;
  logic [23:0] output_latch;
  logic [2:0] irq_status;
  logic [2:0] irq_mask;
  logic carry_toggle_ff;
  logic borrow_toggle_ff;
  logic match_toggle_ff;
  logic [23:0] count_value;
  logic carry_ev;
  logic borrow_ev;
  logic match_lvl;
  logic match_d;

  wire access = psel & penable;
  wire capture = access & ~pready;
  wire done = access & pready;
  wire wr_done = done & pwrite;
  wire rd_done = done & ~pwrite;
  wire hit_in = (paddr == cdio_pkg::OFS_INPUT_SETUP);
  wire hit_out = (paddr == cdio_pkg::OFS_OUTPUT_SETUP);
  wire hit_pre = (paddr == cdio_pkg::OFS_PRESET);
  wire hit_lat = (paddr == cdio_pkg::OFS_LATCH);
  wire hit_cnt = (paddr == cdio_pkg::OFS_COUNT);
  wire hit_tog = (paddr == cdio_pkg::OFS_TOGGLES);
  wire hit_ist = (paddr == cdio_pkg::OFS_IRQ_STATUS);
  wire hit_msk = (paddr == cdio_pkg::OFS_IRQ_MASK);
  wire hit_cmd = (paddr == cdio_pkg::OFS_COMMAND);
  wire mapped = hit_in | hit_out | hit_pre | hit_lat | hit_cnt | hit_tog | hit_ist | hit_msk | hit_cmd;
  wire wr_in = wr_done & hit_in;
  wire wr_cmd = wr_done & hit_cmd;
  wire wr_out = wr_done & hit_out;
  wire wr_pre = wr_done & hit_pre;
  wire wr_msk = wr_done & hit_msk;
  wire rd_ist = rd_done & hit_ist;

  wire [2:0] toggle_vec;
  assign toggle_vec[cdio_pkg::EV_BORROW] = borrow_toggle_ff;
  assign toggle_vec[cdio_pkg::EV_CARRY] = carry_toggle_ff;
  assign toggle_vec[cdio_pkg::EV_MATCH] = match_toggle_ff;

  wire [31:0] rd_value = ({32{hit_in}} & {26'h0, input_setup_register}) |
                         ({32{hit_out}} & {26'h0, output_setup_register}) |
                         ({32{hit_pre}} & {8'h0, preset_register}) |
                         ({32{hit_lat}} & {8'h0, output_latch}) |
                         ({32{hit_cnt}} & {8'h0, count_value}) |
                         ({32{hit_tog}} & {29'h0, toggle_vec}) |
                         ({32{hit_ist}} & {29'h0, irq_status}) |
                         ({32{hit_msk}} & {29'h0, irq_mask});

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= capture;
      prdata <= (capture & ~pwrite) ? rd_value : 32'h0;
      pslverr <= capture & ~mapped;
    end
  end

  // ****************************************
  // setup registers
  // ****************************************
  // one short block per register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_setup_register <= cdio_pkg::INPUT_SETUP_RST;
    end else if (wr_in) begin
      input_setup_register <= pwdata[5:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_setup_register <= cdio_pkg::OUTPUT_SETUP_RST;
    end else if (wr_out) begin
      output_setup_register <= pwdata[5:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      preset_register <= cdio_pkg::PRESET_RST;
    end else if (wr_pre) begin
      preset_register <= pwdata[23:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= cdio_pkg::IRQ_MASK_RST;
    end else if (wr_msk) begin
      irq_mask <= pwdata[2:0];
    end
  end

  // ****************************************
  // pin functions
  // ****************************************
  wire dir_mode = input_setup_register[cdio_pkg::IN_DIR_MODE];
  wire gate_mode = input_setup_register[cdio_pkg::IN_GATE_SEL];
  wire latch_mode = input_setup_register[cdio_pkg::IN_LOAD_SEL];
  wire div_n = output_setup_register[cdio_pkg::OUT_DIVN];
  wire [1:0] out_sel = output_setup_register[cdio_pkg::OUT_SEL_HI:cdio_pkg::OUT_SEL_LO];

  // gate mode: low passes count pulses, high blocks them
  wire gate_open = ~gate_mode | ~gate_s;
  wire inputs_on = input_setup_register[cdio_pkg::IN_ENABLE] & gate_open;
  // reset mode: low level holds the counter cleared
  wire ext_clear = ~gate_mode & ~gate_s;

  wire hw_up = inputs_on & (dir_mode ? (a_rise & ~b_s) : a_rise);
  wire hw_down = inputs_on & (dir_mode ? (a_rise & b_s) : b_rise);
  wire sw_inc = wr_in & pwdata[cdio_pkg::IN_SW_INC];
  wire sw_dec = wr_in & pwdata[cdio_pkg::IN_SW_DEC];
  wire up_req = hw_up | sw_inc;
  wire down_req = hw_down | sw_dec;

  wire core_clear = ext_clear | (wr_cmd & pwdata[cdio_pkg::CMD_RESET]);
  wire core_load = (load_fall & ~latch_mode) | (wr_cmd & pwdata[cdio_pkg::CMD_LOAD]);
  wire latch_take = (load_fall & latch_mode) | (wr_cmd & pwdata[cdio_pkg::CMD_LATCH]);
  wire clr_toggles = wr_cmd & pwdata[cdio_pkg::CMD_CLR_TOGGLES];

  // ****************************************
  // counter core
  // ****************************************
  cdio_count_core #(
    .W(cdio_pkg::COUNT_W)
  ) u_core (
    .clk(pclk),
    .rst_n(presetn),
    .clear(core_clear),
    .load(core_load),
    .up_step(up_req),
    .down_step(down_req),
    .div_n(div_n),
    .preset(preset_register),
    .count(count_value),
    .carry(carry_ev),
    .borrow(borrow_ev),
    .match(match_lvl)
  );

  wire match_rise = match_lvl & ~match_d;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_latch <= 24'h0;
    end else if (latch_take) begin
      output_latch <= count_value;
    end
  end

  // previous equality level for the rise detector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_d <= 1'b0;
    end else begin
      match_d <= match_lvl;
    end
  end

  // ****************************************
  // toggle flip-flops
  // ****************************************
  // an event in the clearing cycle still toggles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      carry_toggle_ff <= 1'b0;
      borrow_toggle_ff <= 1'b0;
      match_toggle_ff <= 1'b0;
    end else begin
      carry_toggle_ff <= (clr_toggles ? 1'b0 : carry_toggle_ff) ^ carry_ev;
      borrow_toggle_ff <= (clr_toggles ? 1'b0 : borrow_toggle_ff) ^ borrow_ev;
      match_toggle_ff <= (clr_toggles ? 1'b0 : match_toggle_ff) ^ match_rise;
    end
  end

  // ****************************************
  // output pins
  // ****************************************
  wire sel_low = (out_sel == cdio_pkg::SEL_LOW);
  wire sel_toggle = (out_sel == cdio_pkg::SEL_TOGGLE);
  wire sel_high = (out_sel == cdio_pkg::SEL_HIGH);
  wire next_carry_pin = sel_low ? ~carry_ev :
                        sel_toggle ? carry_toggle_ff :
                        sel_high ? carry_ev : ~match_lvl;
  wire next_borrow_pin = sel_low ? ~borrow_ev :
                         sel_toggle ? borrow_toggle_ff :
                         sel_high ? borrow_ev : match_toggle_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      carry_pin <= 1'b1;
      borrow_pin <= 1'b1;
    end else begin
      carry_pin <= next_carry_pin;
      borrow_pin <= next_borrow_pin;
    end
  end

  // ****************************************
  // interrupts
  // ****************************************
  wire [2:0] events;
  assign events[cdio_pkg::EV_BORROW] = borrow_ev;
  assign events[cdio_pkg::EV_CARRY] = carry_ev;
  assign events[cdio_pkg::EV_MATCH] = match_rise;
  // clear only the bits the read reported; new events win
  wire [2:0] irq_clear = rd_ist ? prdata[2:0] : 3'h0;
  wire [2:0] next_irq_status = (irq_status & ~irq_clear) | events;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= 3'h0;
      irq <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq <= |(next_irq_status & irq_mask);
    end
  end
endmodule
`default_nettype wire

// [cdio_pkg.sv]
// Purpose: shared constants of the counter discrete-pin control block
// Assumes: APB register map, 32-bit data, byte offsets
// Notes: all offsets are byte addresses of aligned words
`default_nettype none
package cdio_pkg;
  // ****************************************
  // widths
  // ****************************************
  localparam int unsigned COUNT_W = 24;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned SETUP_W = 6;
  localparam int unsigned EV_W = 3;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] OFS_INPUT_SETUP = 8'h00;
  localparam logic [7:0] OFS_OUTPUT_SETUP = 8'h04;
  localparam logic [7:0] OFS_PRESET = 8'h08;
  localparam logic [7:0] OFS_LATCH = 8'h0C;
  localparam logic [7:0] OFS_COUNT = 8'h10;
  localparam logic [7:0] OFS_TOGGLES = 8'h14;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h1C;
  localparam logic [7:0] OFS_COMMAND = 8'h20;

  // ****************************************
  // input setup fields
  // ****************************************
  localparam int unsigned IN_DIR_MODE = 0;
  localparam int unsigned IN_SW_INC = 1;
  localparam int unsigned IN_SW_DEC = 2;
  localparam int unsigned IN_ENABLE = 3;
  localparam int unsigned IN_GATE_SEL = 4;
  localparam int unsigned IN_LOAD_SEL = 5;

  // ****************************************
  // output setup fields
  // ****************************************
  localparam int unsigned OUT_DIVN = 2;
  localparam int unsigned OUT_SEL_LO = 4;
  localparam int unsigned OUT_SEL_HI = 5;
  localparam logic [1:0] SEL_LOW = 2'h0;
  localparam logic [1:0] SEL_TOGGLE = 2'h1;
  localparam logic [1:0] SEL_HIGH = 2'h2;
  localparam logic [1:0] SEL_MATCH = 2'h3;

  // ****************************************
  // command bits, event bits
  // ****************************************
  localparam int unsigned CMD_LOAD = 0;
  localparam int unsigned CMD_LATCH = 1;
  localparam int unsigned CMD_CLR_TOGGLES = 2;
  localparam int unsigned CMD_RESET = 3;
  localparam int unsigned EV_BORROW = 0;
  localparam int unsigned EV_CARRY = 1;
  localparam int unsigned EV_MATCH = 2;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [5:0] INPUT_SETUP_RST = 6'h00;
  localparam logic [5:0] OUTPUT_SETUP_RST = 6'h00;
  localparam logic [23:0] PRESET_RST = 24'hFFFFFF;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;
  localparam logic [3:0] PIN_IDLE = 4'hF;
endpackage
`default_nettype wire

// [cdio_sync.sv]
// Purpose: two-flop synchroniser, one per pin
// Assumes: inputs asynchronous to clk
// Notes: first stage read only by second stage
`timescale 1ns/1ns
`default_nettype none
module cdio_sync #(
  parameter int unsigned WIDTH = 4,
  parameter logic [WIDTH-1:0] RST_VAL = '1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pins in, synchronised out
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta;
      logic hold;
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta <= RST_VAL[i];
          hold <= RST_VAL[i];
        end else begin
          meta <= din[i];
          hold <= meta;
        end
      end
      assign dout[i] = hold;
    end
  endgenerate
endmodule
`default_nettype wire

// [cdio_count_core.sv]
// Purpose: up/down counter with preset load, clear and divide-by-N wrap
// Assumes: one step request per cycle at most per direction
// Notes: carry, borrow are one-cycle pulses; match is a level
`timescale 1ns/1ns
`default_nettype none
module cdio_count_core #(
  parameter int unsigned W = 24
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic clear,
  input wire logic load,
  input wire logic up_step,
  input wire logic down_step,
  input wire logic div_n,
  input wire logic [W-1:0] preset,
  // state
  output logic [W-1:0] count,
  output logic carry,
  output logic borrow,
  output logic match
);
  wire up_only = up_step & ~down_step;
  wire down_only = down_step & ~up_step;
  wire at_max = (count == {W{1'b1}});
  wire at_zero = (count == {W{1'b0}});
  // divide-by-N: up wraps at preset, down reloads preset
  wire up_wrap = div_n ? (count == preset) : at_max;
  wire [W-1:0] up_value = up_wrap ? {W{1'b0}} : count + {{(W-1){1'b0}}, 1'b1};
  wire [W-1:0] down_wrap_value = div_n ? preset : {W{1'b1}};
  wire [W-1:0] down_value = at_zero ? down_wrap_value : count - {{(W-1){1'b0}}, 1'b1};
  wire stepping = ~clear & ~load;
  wire [W-1:0] next_count = clear ? {W{1'b0}} :
                            load ? preset :
                            up_only ? up_value :
                            down_only ? down_value : count;
  wire next_carry = stepping & up_only & up_wrap;
  wire next_borrow = stepping & down_only & at_zero;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= {W{1'b0}};
      carry <= 1'b0;
      borrow <= 1'b0;
      match <= 1'b0;
    end else begin
      count <= next_count;
      carry <= next_carry;
      borrow <= next_borrow;
      match <= (next_count == preset);
    end
  end
endmodule
`default_nettype wire

// [cdio_props.sv]
// Purpose: port-level checks of the counter pin control block
// Assumes: sees only the top module ports
// Notes: output select is tracked from apb writes
`timescale 1ns/1ns
`default_nettype none
module cdio_props (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pins
  input wire logic count_a,
  input wire logic count_b,
  input wire logic gate_or_reset_pin,
  input wire logic load_target_pin,
  input wire logic carry_pin,
  input wire logic borrow_pin,
  input wire logic irq
);
  logic [1:0] sel;
  logic [1:0] age;
  wire logic settled = (age == 2'h3);
  wire logic sel_wr = psel && penable && pready && pwrite && (paddr == cdio_pkg::OFS_OUTPUT_SETUP);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel <= 2'h0;
      age <= 2'h0;
    end else if (sel_wr) begin
      sel <= pwdata[5:4];
      age <= 2'h0;
    end else if (!settled) begin
      age <= age + 2'h1;
    end
  end
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_access: assert property (pready |-> psel && penable && $past(penable))
    else $error("pready outside an access phase");
  a_err_unmapped: assert property (pready && paddr > 8'h20 |-> pslverr)
    else $error("no error on unmapped address");
  a_err_mapped: assert property (pready && paddr <= 8'h20 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("error on mapped address");
  a_rdata_quiet: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
    else $error("read data outside read answer");
  a_carry_low: assert property (settled && sel == cdio_pkg::SEL_LOW && !carry_pin |=> carry_pin)
    else $error("low carry longer than one cycle");
  a_carry_high: assert property (settled && sel == cdio_pkg::SEL_HIGH && carry_pin |=> !carry_pin)
    else $error("high carry longer than one cycle");
  a_borrow_low: assert property (settled && sel == cdio_pkg::SEL_LOW && !borrow_pin |=> borrow_pin)
    else $error("low borrow longer than one cycle");
  a_borrow_high: assert property (settled && sel == cdio_pkg::SEL_HIGH && borrow_pin |=> !borrow_pin)
    else $error("high borrow longer than one cycle");
  c_unmapped: cover property (pready && pslverr);
  c_carry_high: cover property (settled && sel == cdio_pkg::SEL_HIGH && carry_pin);
  c_irq: cover property ($rose(irq));
endmodule
bind cdio_top cdio_props u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .count_a(count_a),
  .count_b(count_b), .gate_or_reset_pin(gate_or_reset_pin), .load_target_pin(load_target_pin),
  .carry_pin(carry_pin), .borrow_pin(borrow_pin), .irq(irq)
);
`default_nettype wire

// [cdio_pulse_src.sv]
// Purpose: count pulse source on the a and b pins
// Assumes: one request pulse at a time
// Notes: idle low, pulse high for half the period
`timescale 1ns/1ns
`default_nettype none
module cdio_pulse_src #(
  parameter int HALF = 17
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // requests
  input wire logic fire_a,
  input wire logic fire_b,
  // pins
  output logic count_a,
  output logic count_b,
  output logic busy
);
  logic [7:0] cnt;
  logic on_b;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 8'h00;
      on_b <= 1'b0;
    end else if (cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
    end else if (fire_a || fire_b) begin
      cnt <= 8'(2 * HALF);
      on_b <= fire_b;
    end
  end
  // period of 340 ns keeps below 3 MHz
  assign busy = (cnt != 8'h00);
  assign count_a = busy && !on_b && (cnt > 8'(HALF));
  assign count_b = busy && on_b && (cnt > 8'(HALF));
endmodule
`default_nettype wire

// [testbench.sv]
// Purpose: self-checking bench of the counter pin control block
// Assumes: one wait state apb, pins synchronised
// Notes: model of count, preset, toggles and status
`timescale 1ns/1ns
`default_nettype none
`define CHK(G, X) begin compares++; if ((G) !== (X)) begin mismatches++; $display("ERROR %0t: mismatch", $time); end end
module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, count_a, count_b, carry_pin, borrow_pin, irq, busy, err;
  logic fire_a = 1'b0;
  logic fire_b = 1'b0;
  logic gate = 1'b1;
  logic load = 1'b1;
  logic [31:0] seed = 32'h1C5C;
  int mismatches = 0;
  int compares = 0;
  int n_cy = 0;
  int n_bw = 0;
  int c0 = 0;
  int c1 = 0;
  logic act = 1'b0;
  // 800 ns after a write at a 10 ns clock
  localparam int WR_GAP = 80;
  int m_count = 0;
  int m_preset = 24'hFFFFFF;
  int m_tog = 0;
  int m_stat = 0;
  int m_divn = 0;
  bit m_eq = 1'b0;
  int rst_q[$] = '{0, 0, 24'hFFFFFF, 0, 0, 0, 0, 0, 0};
  always #5 pclk = ~pclk;
  // cycles spent at the active level of the selected pin mode
  always @(posedge pclk) begin
    n_cy += int'(carry_pin === act);
    n_bw += int'(borrow_pin === act);
  end
  cdio_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .count_a(count_a), .count_b(count_b), .gate_or_reset_pin(gate), .load_target_pin(load),
    .carry_pin(carry_pin), .borrow_pin(borrow_pin), .irq(irq));
  cdio_pulse_src src (.pclk(pclk), .presetn(presetn), .fire_a(fire_a), .fire_b(fire_b),
    .count_a(count_a), .count_b(count_b), .busy(busy));
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function void sync_eq();
    if (m_count == m_preset && !m_eq) begin
      m_tog ^= 4;
      m_stat |= 4;
    end
    m_eq = (m_count == m_preset);
  endfunction
  function void step(int up);
    if (up && m_count == (m_divn ? m_preset : 24'hFFFFFF)) begin
      m_count = 0;
      m_tog ^= 2;
      m_stat |= 2;
    end else if (up) begin
      m_count++;
    end else if (m_count == 0) begin
      m_count = m_divn ? m_preset : 24'hFFFFFF;
      m_tog ^= 1;
      m_stat |= 1;
    end else begin
      m_count--;
    end
    sync_eq();
  endfunction
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (w) repeat (WR_GAP) @(posedge pclk);
  endtask
  task rchk(input logic [7:0] a, input int x);
    apb(1'b0, a, 32'h0);
    `CHK(q, 32'(x))
  endtask
  task pulse(input int up, input int counts);
    if (up) fire_a <= 1'b1;
    else fire_b <= 1'b1;
    @(posedge pclk);
    fire_a <= 1'b0;
    fire_b <= 1'b0;
    @(posedge pclk);
    while (busy === 1'b1) begin
      @(posedge pclk);
    end
    repeat (6) @(posedge pclk);
    if (counts) step(up);
  endtask
  task pin(input logic g, input logic l);
    gate <= g;
    load <= l;
    repeat (8) @(posedge pclk);
  endtask
  task test_done();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    $display("ERROR %0t: watchdog", $time);
    test_done();
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 9; i++) rchk(8'(4 * i), rst_q[i]);
    apb(1'b0, 8'h24, 32'h0);
    `CHK(err, 1'b1)
    apb(1'b1, cdio_pkg::OFS_COUNT, 32'h5);
    rchk(cdio_pkg::OFS_COUNT, 0);
    $display("test reset done");
    apb(1'b1, cdio_pkg::OFS_INPUT_SETUP, 32'h18);
    pin(1'b0, 1'b1);
    for (int i = 0; i < 3; i++) pulse(1, 1);
    rchk(cdio_pkg::OFS_COUNT, m_count);
    pin(1'b1, 1'b1);
    pulse(1, 0);
    pulse(0, 0);
    rchk(cdio_pkg::OFS_COUNT, m_count);
    pin(1'b0, 1'b1);
    pulse(0, 1);
    pin(1'b1, 1'b1);
    apb(1'b1, cdio_pkg::OFS_INPUT_SETUP, 32'h38);
    pin(1'b1, 1'b0);
    pin(1'b1, 1'b1);
    rchk(cdio_pkg::OFS_LATCH, m_count);
    $display("test gate_latch done");
    m_preset = int'(rnd() & 32'h00FFFFFF);
    apb(1'b1, cdio_pkg::OFS_PRESET, m_preset);
    sync_eq();
    apb(1'b1, cdio_pkg::OFS_INPUT_SETUP, 32'h18);
    pin(1'b1, 1'b0);
    pin(1'b1, 1'b1);
    m_count = m_preset;
    sync_eq();
    rchk(cdio_pkg::OFS_COUNT, m_count);
    apb(1'b1, cdio_pkg::OFS_INPUT_SETUP, 32'h08);
    pin(1'b0, 1'b1);
    m_count = 0;
    sync_eq();
    rchk(cdio_pkg::OFS_COUNT, 0);
    pin(1'b1, 1'b1);
    $display("test load_reset done");
    apb(1'b1, cdio_pkg::OFS_INPUT_SETUP, 32'h18);
    pin(1'b0, 1'b1);
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, cdio_pkg::OFS_OUTPUT_SETUP, 32'(s << 4));
      m_preset = 24'hFFFFFF;
      apb(1'b1, cdio_pkg::OFS_PRESET, m_preset);
      sync_eq();
      apb(1'b1, cdio_pkg::OFS_COMMAND, 32'h1);
      m_count = m_preset;
      sync_eq();
      act = 1'(s != 0);
      c0 = n_cy;
      c1 = n_bw;
      pulse(1, 1);
      `CHK(carry_pin, 1'(s == 0 || (s == 1 && m_tog[1]) || (s == 3 && !m_eq)))
      if (s % 2 == 0) `CHK(n_cy - c0, 1)
      pulse(0, 1);
      `CHK(borrow_pin, 1'(s == 0 || (s == 1 && m_tog[0]) || (s == 3 && m_tog[2])))
      if (s % 2 == 0) `CHK(n_bw - c1, 1)
      rchk(cdio_pkg::OFS_TOGGLES, m_tog);
    end
    $display("test outputs done");
    rchk(cdio_pkg::OFS_IRQ_STATUS, m_stat);
    m_stat = 0;
    apb(1'b1, cdio_pkg::OFS_IRQ_MASK, 32'h1);
    apb(1'b1, cdio_pkg::OFS_COMMAND, 32'h8);
    m_count = 0;
    sync_eq();
    pulse(0, 1);
    `CHK(irq, 1'b1)
    apb(1'b1, cdio_pkg::OFS_IRQ_MASK, 32'h0);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b0)
    rchk(cdio_pkg::OFS_IRQ_STATUS, m_stat);
    m_stat = 0;
    apb(1'b1, cdio_pkg::OFS_IRQ_MASK, 32'h7);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b0)
    $display("test irq done");
    apb(1'b1, cdio_pkg::OFS_OUTPUT_SETUP, 32'h4);
    m_divn = 1;
    m_preset = int'(rnd() % 6) + 2;
    apb(1'b1, cdio_pkg::OFS_PRESET, m_preset);
    sync_eq();
    apb(1'b1, cdio_pkg::OFS_COMMAND, 32'h1);
    m_count = m_preset;
    sync_eq();
    pulse(1, 1);
    rchk(cdio_pkg::OFS_COUNT, m_count);
    pulse(0, 1);
    rchk(cdio_pkg::OFS_COUNT, m_count);
    rchk(cdio_pkg::OFS_TOGGLES, m_tog);
    $display("test divide done");
    apb(1'b1, cdio_pkg::OFS_INPUT_SETUP, 32'h1B);
    step(1);
    pulse(1, 1);
    rchk(cdio_pkg::OFS_COUNT, m_count);
    apb(1'b1, cdio_pkg::OFS_COMMAND, 32'h6);
    m_tog = 0;
    rchk(cdio_pkg::OFS_TOGGLES, m_tog);
    rchk(cdio_pkg::OFS_LATCH, m_count);
    $display("test modes done");
    test_done();
  end
endmodule
`default_nettype wire
